// ### hdl/crs_supervisor.sv
// Per-circuit release supervision: release, erasure, supervision timers.
// Assumes all event inputs are one-cycle pulses from call control logic
// on sys_clk_i, so no input synchronisers are needed.
`timescale 1ns/1ps
`include "crs_params.svh"

////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) Received clear-forward releases the connection normally.
// (RULE2) Continuity fail, backward failures, early blocking also release.
// (RULE3) Outgoing: erase address data on backward signals or early clear.
// (RULE4) Incoming: erase on national backward, own signals, clear-forward.
// (RULE5) Transit: erase on backward signals, clear-forward, own congestion.
// (RULE6) Unreleasable after clear-forward: block, then release-guard on ack.
// (RULE7) Unreleasable after backward failure: block, clear-forward on ack.
// (RULE8) Missing release-guard within repeat interval resends clear-forward.
// (RULE9) After one minute: alert, stop repeating, out of service, block.
// (RULE10) Send call-failure on time-outs and on otherwise unclassed failures.
// (RULE11) Received call-failure: clear-forward, optional backward signal.
// (RULE12) Outgoing: no erasure within address interval releases and clears.
// (RULE13) Outgoing: answer or clear-back interval expiry releases and clears.
// (RULE14) Incoming, transit: no continuity in time releases, call-failure.
// (RULE15) Incoming: no national backward releases, unless other timing used.
// (RULE16) Incoming: address incomplete after complete releases, call-failure.
// (RULE17) Incoming, transit: call-failure repeats until clear-forward.
// (RULE18) A minute without clear-forward: stop, alert, out of service, block.
// (RULE19) Incoming: no clear-forward after own clear-back releases, clears.
// (RULE20) Transit: no erasure within address interval releases, call-failure.
// (RULE21) Repeat blocking/unblocking until acked; acknowledge received ones.
// (RULE22) No ack in a minute: alert, stop repeating, out of service.
// (RULE23) Range timers clamp expiry; repeats restart, guards do not.
module crs_supervisor
    import crs_pkg::*;
#(
    parameter int TICK_CYC = `CRS_TICK_NS / `CRS_CLK_NS
) (
    // Clock and reset
    input  logic         sys_clk_i,
    input  logic         rst_n_i,
    // Configuration
    input  crs_role_type role_i,
    input  logic [15:0]  rep_ms_i,
    input  logic [15:0]  adr_ms_i,
    input  logic [15:0]  cot_ms_i,
    input  logic [15:0]  ans_ms_i,
    input  logic [15:0]  clb_ms_i,
    input  logic         release_ok_i,
    input  logic         auto_repeat_i,
    input  logic         pass_back_i,
    input  logic         cont_expected_i,
    input  logic         adr_inc_timing_i,
    // Signals received from the peer or national side
    input  logic         iam_i,
    input  logic         addr_msg_i,
    input  logic         rx_clear_fwd_i,
    input  logic         rx_release_guard_i,
    input  logic         rx_addr_complete_i,
    input  logic         rx_addr_incomplete_i,
    input  logic         rx_congestion_i,
    input  logic         rx_line_cond_i,
    input  logic         rx_call_fail_i,
    input  logic         rx_blocking_i,
    input  logic         rx_unblocking_i,
    input  logic         rx_block_ack_i,
    input  logic         rx_unblock_ack_i,
    input  logic         rx_continuity_i,
    input  logic         rx_clear_back_i,
    input  logic         rx_answer_i,
    input  logic         nat_bwd_i,
    input  logic         nat_clear_fwd_i,
    input  logic         cc_fail_i,
    // Local call control events
    input  logic         tx_addr_complete_i,
    input  logic         tx_bwd_fail_i,
    input  logic         tx_reset_i,
    input  logic         own_cong_i,
    input  logic         tx_clear_back_i,
    input  logic         attempt_fail_i,
    input  logic         maint_block_i,
    input  logic         maint_unblock_i,
    // Signals to send and local indications
    output logic         tx_clear_fwd_o,
    output logic         tx_release_guard_o,
    output logic         tx_call_fail_o,
    output logic         tx_blocking_o,
    output logic         tx_unblocking_o,
    output logic         tx_block_ack_o,
    output logic         tx_unblock_ack_o,
    output logic         release_o,
    output logic         erase_o,
    output logic         bwd_ind_o,
    output logic         maint_alert_o,
    output logic         out_of_service_o,
    output logic         blocked_o
);

    localparam int NT = `CRS_NUM_TMR;

    // Clamp a programmed expiry into its permitted range
    function automatic logic [15:0] crs_clamp(input logic [15:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction : crs_clamp

    crs_state_type st_r, st_nxt;
    crs_blk_type   bk_r, bk_nxt;
    logic [14:0]   tick_cnt_r;
    logic          tick_r;
    logic [15:0]   tcnt_r [NT];
    logic [NT-1:0] trun_r;
    logic [15:0]   lim    [NT];
    logic [NT-1:0] expd, tstart, tstop;
    logic          out_role, in_role;
    logic          bwd_seen_r, ac_gen_r;
    logic          cf_snd, rg_snd, cfl_snd, rel, bwd_snd, blk_req, alert;
    logic          oos_set, oos_clr, blk_snd, ubl_snd, blkd_set;
    logic          rx_bf, early_blk, to_out, to_inc, inc_ai, erase_ev;

    assign out_role = (role_i == ROLE_OUT);
    assign in_role  = (role_i == ROLE_IN);

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick; a long divide keeps the timers only 16 bits wide
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tick_cnt_r <= 15'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 15'(TICK_CYC - 1)) begin
            tick_cnt_r <= 15'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 15'h0001;
            tick_r     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timer limits, range timers clamped
    always_comb begin
        lim[T_CFR] = crs_clamp(rep_ms_i, `CRS_REP_MIN_MS, `CRS_REP_MAX_MS); // RULE23
        lim[T_CLR] = lim[T_CFR];
        lim[T_BKR] = lim[T_CFR];
        lim[T_CFG] = `CRS_GUARD_MS;
        lim[T_CLG] = `CRS_GUARD_MS;
        lim[T_BKG] = `CRS_GUARD_MS;
        lim[T_ADR] = crs_clamp(adr_ms_i, `CRS_ADR_MIN_MS, `CRS_ADR_MAX_MS); // RULE23
        lim[T_COT] = crs_clamp(cot_ms_i, `CRS_COT_MIN_MS, `CRS_COT_MAX_MS); // RULE23
        lim[T_ANS] = ans_ms_i;
        lim[T_CLB] = clb_ms_i;
        for (int i = 0; i < NT; i++) begin
            expd[i] = trun_r[i] && (tcnt_r[i] >= lim[i]);
        end
    end

    // Timers: start wins, expiry self-stops so each fires one cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trun_r <= '0;
            for (int i = 0; i < NT; i++) tcnt_r[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (tstart[i]) begin
                    tcnt_r[i] <= 16'h0000;
                    trun_r[i] <= 1'b1;
                end else if (tstop[i] || expd[i]) begin
                    trun_r[i] <= 1'b0;
                end else if (trun_r[i] && tick_r) begin
                    tcnt_r[i] <= tcnt_r[i] + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event decode
    assign rx_bf     = rx_addr_incomplete_i | rx_congestion_i |
                       rx_line_cond_i | rx_call_fail_i;
    assign early_blk = rx_blocking_i && out_role && !bwd_seen_r;
    assign inc_ai    = in_role && ac_gen_r && rx_addr_incomplete_i;
    assign to_out    = (out_role && expd[T_ADR]) || expd[T_ANS] ||
                       expd[T_CLB];
    assign to_inc    = (!out_role && (expd[T_ADR] || expd[T_COT])) || inc_ai;

    // Release state machine, call-failure and blocking supervision
    always_comb begin
        st_nxt   = st_r;
        bk_nxt   = bk_r;
        cf_snd   = 1'b0;
        rg_snd   = 1'b0;
        cfl_snd  = 1'b0;
        rel      = 1'b0;
        bwd_snd  = 1'b0;
        blk_req  = 1'b0;
        alert    = 1'b0;
        oos_set  = 1'b0;
        oos_clr  = 1'b0;
        blk_snd  = 1'b0;
        ubl_snd  = 1'b0;
        blkd_set = 1'b0;
        tstart   = '0;
        tstop    = '0;
        case (st_r)
            ST_IDLE, ST_BUSY: begin
                if (rx_clear_fwd_i && release_ok_i) begin
                    rel    = 1'b1;                               // RULE1
                    rg_snd = 1'b1;
                    st_nxt = ST_IDLE;
                end else if (rx_clear_fwd_i) begin
                    oos_set = 1'b1;                              // RULE6
                    blk_req = 1'b1;
                    st_nxt  = ST_BLK_RG;
                end else if (st_r == ST_BUSY && (to_inc || to_out)) begin
                    rel     = 1'b1;                 // RULE12 RULE13 RULE19
                    cf_snd  = 1'b1;                 // RULE14 RULE15 RULE20
                    cfl_snd = to_inc;                            // RULE10
                    st_nxt  = ST_CF_WAIT;                        // RULE16
                end else if (st_r == ST_BUSY && rx_bf && !release_ok_i) begin
                    oos_set = 1'b1;                              // RULE7
                    blk_req = 1'b1;
                    st_nxt  = ST_BLK_CF;
                end else if (st_r == ST_BUSY &&
                             (rx_bf || cc_fail_i || early_blk)) begin
                    rel     = 1'b1;                              // RULE2
                    cf_snd  = 1'b1;                              // RULE11
                    bwd_snd = rx_call_fail_i && pass_back_i;     // RULE11
                    st_nxt  = ST_CF_WAIT;
                end else if (iam_i) begin
                    st_nxt = ST_BUSY;
                end
            end
            ST_CF_WAIT: begin
                if (rx_release_guard_i) begin
                    tstop[T_CFR] = 1'b1;
                    tstop[T_CFG] = 1'b1;
                    st_nxt       = ST_IDLE;
                end else if (expd[T_CFG]) begin
                    alert        = 1'b1;                         // RULE9
                    oos_set      = 1'b1;
                    blk_req      = 1'b1;
                    tstop[T_CFR] = 1'b1;
                    st_nxt       = ST_OOS;
                end else if (expd[T_CFR]) begin
                    cf_snd = 1'b1;                               // RULE8
                end
            end
            ST_BLK_RG: begin
                if (rx_block_ack_i) begin
                    rg_snd = 1'b1;                               // RULE6
                    st_nxt = ST_OOS;
                end
            end
            ST_BLK_CF: begin
                if (rx_block_ack_i) begin
                    cf_snd = 1'b1;                               // RULE7
                    st_nxt = ST_CF_WAIT;
                end
            end
            ST_OOS: begin
                if (bk_r == B_UBL && rx_unblock_ack_i) st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase

        // Clear-forward: repeat timer restarts, guard only on first send
        tstart[T_CFR] = cf_snd;                                  // RULE23
        tstart[T_CFG] = cf_snd && (st_r != ST_CF_WAIT);          // RULE23

        // Call-failure supervision toward the incoming circuit
        if (attempt_fail_i) cfl_snd = 1'b1;                      // RULE10
        if (rx_clear_fwd_i) begin
            tstop[T_CLR] = 1'b1;
            tstop[T_CLG] = 1'b1;
        end else if (expd[T_CLG]) begin
            alert        = 1'b1;                                 // RULE18
            oos_set      = 1'b1;
            blk_req      = 1'b1;
            tstop[T_CLR] = 1'b1;
        end else if (expd[T_CLR]) begin
            cfl_snd       = 1'b1;                                // RULE17
            tstart[T_CLR] = 1'b1;
        end
        if (!out_role && (cfl_snd || tx_bwd_fail_i) && !expd[T_CLR]) begin
            tstart[T_CLR] = 1'b1;                                // RULE17
            tstart[T_CLG] = !trun_r[T_CLG];                      // RULE23
        end

        // Blocking and unblocking with acknowledgement supervision
        case (bk_r)
            B_IDLE: begin
                if (blk_req || maint_block_i) begin
                    blk_snd = 1'b1;
                    bk_nxt  = B_BLK;
                end else if (maint_unblock_i) begin
                    ubl_snd = 1'b1;
                    bk_nxt  = B_UBL;
                end
                tstart[T_BKR] = blk_snd || ubl_snd;
                tstart[T_BKG] = blk_snd || ubl_snd;
            end
            B_BLK, B_UBL: begin
                if ((bk_r == B_BLK && rx_block_ack_i) ||
                    (bk_r == B_UBL && rx_unblock_ack_i)) begin
                    blkd_set     = (bk_r == B_BLK);
                    oos_clr      = (bk_r == B_UBL);
                    tstop[T_BKR] = 1'b1;
                    tstop[T_BKG] = 1'b1;
                    bk_nxt       = B_IDLE;
                end else if (expd[T_BKG]) begin
                    alert        = 1'b1;                         // RULE22
                    oos_set      = 1'b1;
                    tstop[T_BKR] = 1'b1;
                    bk_nxt       = B_IDLE;
                end else if (expd[T_BKR]) begin
                    blk_snd       = (bk_r == B_BLK);             // RULE21
                    ubl_snd       = (bk_r == B_UBL);
                    tstart[T_BKR] = 1'b1;                        // RULE23
                end
            end
            default: bk_nxt = B_IDLE;
        endcase

        // Call setup supervision timers
        tstart[T_ADR] = (addr_msg_i || iam_i) &&
                        !(in_role && adr_inc_timing_i);          // RULE15
        tstart[T_COT] = iam_i && !out_role && cont_expected_i;   // RULE14
        tstart[T_ANS] = iam_i && out_role;                       // RULE13
        tstart[T_CLB] = out_role ? rx_clear_back_i :
                        (in_role && tx_clear_back_i);            // RULE19
        tstop[T_ADR]  = rel || (in_role ? nat_bwd_i :
                        (rx_addr_complete_i || rx_bf));
        tstop[T_COT]  = rel || rx_continuity_i;
        tstop[T_ANS]  = rel || rx_answer_i;
        tstop[T_CLB]  = rel || (out_role ? nat_clear_fwd_i : rx_clear_fwd_i);
    end

    // Erasure of stored address and routing data, per role
    always_comb begin
        case (role_i)
            ROLE_OUT: erase_ev = rx_addr_complete_i || rx_bf ||
                                 (rel && !auto_repeat_i);        // RULE3
            ROLE_IN:  erase_ev = nat_bwd_i || tx_addr_complete_i ||
                                 tx_bwd_fail_i || tx_reset_i ||
                                 rx_clear_fwd_i;                 // RULE4
            ROLE_TRANSIT: erase_ev = rx_addr_complete_i || rx_bf ||
                                 rx_clear_fwd_i || own_cong_i;   // RULE5
            default:  erase_ev = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_r <= ST_IDLE;
            bk_r <= B_IDLE;
        end else begin
            st_r <= st_nxt;
            bk_r <= bk_nxt;
        end
    end

    // Call history flags, cleared once the call leaves busy
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || st_r != ST_BUSY) begin
            bwd_seen_r <= 1'b0;
            ac_gen_r   <= 1'b0;
        end else begin
            bwd_seen_r <= bwd_seen_r || rx_addr_complete_i || rx_bf ||
                          rx_answer_i;
            ac_gen_r   <= ac_gen_r || tx_addr_complete_i;
        end
    end

    // Sticky status; a set in the same cycle beats a clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            out_of_service_o <= 1'b0;
            blocked_o        <= 1'b0;
        end else begin
            out_of_service_o <= oos_set || (out_of_service_o && !oos_clr);
            blocked_o        <= blkd_set || (blocked_o && !oos_clr);
        end
    end

    // Signal pulses; acks to peer blocking are never held back by a call
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_clear_fwd_o     <= 1'b0;
            tx_release_guard_o <= 1'b0;
            tx_call_fail_o     <= 1'b0;
            tx_blocking_o      <= 1'b0;
            tx_unblocking_o    <= 1'b0;
            tx_block_ack_o     <= 1'b0;
            tx_unblock_ack_o   <= 1'b0;
            release_o          <= 1'b0;
            erase_o            <= 1'b0;
            bwd_ind_o          <= 1'b0;
            maint_alert_o      <= 1'b0;
        end else begin
            tx_clear_fwd_o     <= cf_snd;
            tx_release_guard_o <= rg_snd;
            tx_call_fail_o     <= cfl_snd;
            tx_blocking_o      <= blk_snd;
            tx_unblocking_o    <= ubl_snd;
            tx_block_ack_o     <= rx_blocking_i;                 // RULE21
            tx_unblock_ack_o   <= rx_unblocking_i;               // RULE21
            release_o          <= rel;
            erase_o            <= erase_ev;
            bwd_ind_o          <= bwd_snd;
            maint_alert_o      <= alert;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_busy_fail;
        st_r == ST_BUSY && rx_congestion_i && release_ok_i && !to_out &&
        !to_inc;
    endsequence
    sequence s_blk_ack_rg;
        st_r == ST_BLK_RG ##0 rx_block_ack_i;
    endsequence

    a_cf_release: assert property (                              // RULE1
        st_r == ST_IDLE && rx_clear_fwd_i && release_ok_i
        |=> release_o && tx_release_guard_o && st_r == ST_IDLE)
        else $error("clear-forward did not release");
    a_norm_rel: assert property (s_busy_fail                     // RULE2
        |=> release_o && tx_clear_fwd_o ##1 st_r == ST_CF_WAIT)
        else $error("congestion did not release");
    a_erase_out: assert property (                               // RULE3
        out_role && rx_addr_complete_i |=> erase_o)
        else $error("outgoing erase missing");
    a_erase_in: assert property (                                // RULE4
        in_role && tx_reset_i |=> erase_o)
        else $error("incoming erase missing");
    a_erase_tr: assert property (                                // RULE5
        role_i == ROLE_TRANSIT && own_cong_i |=> erase_o)
        else $error("transit erase missing");
    a_blk_rg_ack: assert property (s_blk_ack_rg                  // RULE6
        |=> tx_release_guard_o && out_of_service_o)
        else $error("release-guard not sent after block ack");
    a_cf_repeat: assert property (                               // RULE8
        st_r == ST_CF_WAIT && expd[T_CFR] && !expd[T_CFG] &&
        !rx_release_guard_i |=> tx_clear_fwd_o ##1 trun_r[T_CFR])
        else $error("clear-forward not repeated");
    a_cf_guard: assert property (                                // RULE9
        st_r == ST_CF_WAIT && expd[T_CFG] && !rx_release_guard_i
        |=> maint_alert_o && out_of_service_o && !tx_clear_fwd_o
        ##1 st_r == ST_OOS && !trun_r[T_CFR])
        else $error("clear-forward guard not handled");
    a_blk_ackn: assert property (                                // RULE21
        rx_blocking_i |=> tx_block_ack_o)
        else $error("blocking not acknowledged");
    a_bk_guard: assert property (                                // RULE22
        bk_r != B_IDLE && expd[T_BKG] && !rx_block_ack_i &&
        !rx_unblock_ack_i |=> maint_alert_o && bk_r == B_IDLE)
        else $error("blocking guard not handled");
    a_rep_clamp: assert property (                               // RULE23
        lim[T_CFR] >= `CRS_REP_MIN_MS && lim[T_CFR] <= `CRS_REP_MAX_MS)
        else $error("repeat limit outside range");

endmodule : crs_supervisor

// ### include/crs_params.svh
// Constants of the circuit release supervisor: clock, timer ranges.
// Assumes a single system clock; timers count in millisecond ticks.
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// System clock period and timer tick period, in ns
`define CRS_CLK_NS      40
`define CRS_TICK_NS     1000000

// Repeat interval range for clear-forward, call-failure, blocking (ms)
`define CRS_REP_MIN_MS  16'd4000
`define CRS_REP_MAX_MS  16'd15000
// Address supervision range (ms)
`define CRS_ADR_MIN_MS  16'd20000
`define CRS_ADR_MAX_MS  16'd30000
// Continuity supervision range (ms)
`define CRS_COT_MIN_MS  16'd10000
`define CRS_COT_MAX_MS  16'd15000
// One-minute guard (ms)
`define CRS_GUARD_MS    16'd60000

// Number of supervision timers
`define CRS_NUM_TMR     10

`endif

// ### include/crs_pkg.sv
// Types shared by the circuit release supervisor.
// Assumes crs_params.svh holds all numeric constants.
package crs_pkg;

    // Exchange role of this circuit end
    typedef enum logic [1:0] {ROLE_OUT, ROLE_IN, ROLE_TRANSIT} crs_role_type;

    // Release state of the circuit
    typedef enum logic [2:0] {
        ST_IDLE, ST_BUSY, ST_CF_WAIT, ST_BLK_RG, ST_BLK_CF, ST_OOS
    } crs_state_type;

    // Blocking / unblocking sequence state
    typedef enum logic [1:0] {B_IDLE, B_BLK, B_UBL} crs_blk_type;

    // Timer indices
    typedef enum {
        T_CFR, T_CFG, T_CLR, T_CLG, T_BKR, T_BKG, T_ADR, T_COT, T_ANS, T_CLB
    } crs_tmr_type;

endpackage : crs_pkg

// ### verification/crs_peer_model.sv
// Peer exchange model: acknowledges blocking, unblocking, clear-forward.
// Assumes one-cycle request pulses on sys_clk_i from the supervisor.
`timescale 1ns/1ps
module crs_peer_model (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Behaviour: slow answers, release-guard enable
    input  wire logic slow_i,
    input  wire logic rg_en_i,
    // Requests from the supervisor
    input  wire logic blk_i,
    input  wire logic ubl_i,
    input  wire logic cf_i,
    // Answers to the supervisor
    output logic      blk_ack_o,
    output logic      ubl_ack_o,
    output logic      rg_o
);
    logic [5:0] blk_r, ubl_r, cf_r;
    ////////////////////////////////////////////////////////////////////
    // Delay lines; a slow peer answers six cycles late
    always_ff @(posedge sys_clk_i) begin
        blk_r <= rst_n_i ? {blk_r[4:0], blk_i} : 6'h00;
        ubl_r <= rst_n_i ? {ubl_r[4:0], ubl_i} : 6'h00;
        cf_r  <= rst_n_i ? {cf_r[4:0], cf_i & rg_en_i} : 6'h00;
    end
    // Every blocking and unblocking request answered once; clear-forward only while rg_en_i is set
    assign blk_ack_o = slow_i ? blk_r[5] : blk_r[0];
    assign ubl_ack_o = slow_i ? ubl_r[5] : ubl_r[0];
    assign rg_o      = slow_i ? cf_r[5] : cf_r[0];
endmodule : crs_peer_model

// ### verification/crs_supervisor_tb_top.sv
// Testbench of the circuit release supervisor against a peer model.
// Assumes crs_pkg compiled first; ticks shortened to one cycle.
`timescale 1ns/1ps
module crs_supervisor_tb_top;
    import crs_pkg::*;
    logic sys_clk_i='0, rst_n_i='0, release_ok_i='1, auto_repeat_i='0,
        pass_back_i='0, cont_expected_i='0, adr_inc_timing_i='0, iam_i='0,
        addr_msg_i='0, rx_clear_fwd_i='0, rx_addr_complete_i='0,
        rx_addr_incomplete_i='0, rx_congestion_i='0, rx_line_cond_i='0,
        rx_call_fail_i='0, rx_blocking_i='0, rx_unblocking_i='0,
        rx_continuity_i='0, rx_clear_back_i='0, rx_answer_i='0,
        nat_bwd_i='0, nat_clear_fwd_i='0, cc_fail_i='0, own_cong_i='0,
        tx_addr_complete_i='0, tx_bwd_fail_i='0, tx_reset_i='0,
        tx_clear_back_i='0, attempt_fail_i='0, maint_block_i='0,
        maint_unblock_i='0, slow='0, rg_en='0;
    logic rx_release_guard_i, rx_block_ack_i, rx_unblock_ack_i;
    logic tx_clear_fwd_o, tx_release_guard_o, tx_call_fail_o, tx_blocking_o,
        tx_unblocking_o, tx_block_ack_o, tx_unblock_ack_o, release_o,
        erase_o, bwd_ind_o, maint_alert_o, out_of_service_o, blocked_o;
    crs_role_type role_i = ROLE_IN;
    logic [15:0] rep_ms_i=16'h0fa0, adr_ms_i=16'h4e20, cot_ms_i=16'h2710,
        ans_ms_i=16'hffff, clb_ms_i=16'hffff;
    int miscompares = 0, comparisons = 0, cycles = 0, n, c = 0;
    crs_supervisor #(.TICK_CYC(1)) i_crs_supervisor (.*);
    crs_peer_model i_crs_peer_model (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .slow_i(slow), .rg_en_i(rg_en),
        .blk_i(tx_blocking_o), .ubl_i(tx_unblocking_o),
        .cf_i(tx_clear_fwd_o), .blk_ack_o(rx_block_ack_i),
        .ubl_ack_o(rx_unblock_ack_i), .rg_o(rx_release_guard_i));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic v, input logic e);
        comparisons++;
        if (v !== e) begin
            miscompares++;
            $display("Error %0t: output mismatch", $time);
        end
    endtask : chk
    task stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // Clock, and a hang guard well beyond the longest scenario
    initial forever #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 70000) begin
            miscompares++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Scenarios: normal release, block ack, congestion repeat, no release
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i) rx_clear_fwd_i <= 1'b1;
        @(posedge sys_clk_i) rx_clear_fwd_i <= 1'b0;
        #1 chk(release_o & tx_release_guard_o, 1'b1);
        chk(erase_o, 1'b1);
        @(posedge sys_clk_i) rx_blocking_i <= 1'b1;
        @(posedge sys_clk_i) rx_blocking_i <= 1'b0;
        #1 chk(tx_block_ack_o, 1'b1);
        // Reset-circuit erases; unblocking is acknowledged
        @(posedge sys_clk_i) {tx_reset_i, rx_unblocking_i} <= 2'h3;
        @(posedge sys_clk_i) {tx_reset_i, rx_unblocking_i} <= 2'h0;
        #1 chk(erase_o & tx_unblock_ack_o, 1'b1);
        @(posedge sys_clk_i) role_i <= ROLE_OUT;
        iam_i <= 1'b1;
        @(posedge sys_clk_i) iam_i <= 1'b0;
        rx_congestion_i <= 1'b1;
        @(posedge sys_clk_i) rx_congestion_i <= 1'b0;
        #1 chk(release_o & tx_clear_fwd_o, 1'b1);
        chk(erase_o, 1'b1);
        for (n = 0; n < 9000; n++) begin
            @(posedge sys_clk_i) if (n == 100) rg_en <= 1'b1;
            #1 if (tx_clear_fwd_o) break;
        end
        chk(n >= 3995 && n <= 4005, 1'b1);
        chk(maint_alert_o, 1'b0);
        repeat (2) @(posedge sys_clk_i); // Let release-guard idle it
        @(posedge sys_clk_i) role_i <= ROLE_IN;
        slow <= 1'b1;
        release_ok_i <= 1'b0;
        rx_clear_fwd_i <= 1'b1;
        @(posedge sys_clk_i) rx_clear_fwd_i <= 1'b0;
        #1 chk(out_of_service_o & tx_blocking_o, 1'b1);
        chk(tx_release_guard_o, 1'b0);
        repeat (20) begin
            @(posedge sys_clk_i) #1 if (tx_release_guard_o) break;
        end
        chk(tx_release_guard_o & blocked_o, 1'b1);
        @(posedge sys_clk_i) maint_unblock_i <= 1'b1;
        @(posedge sys_clk_i) maint_unblock_i <= 1'b0;
        #1 chk(tx_unblocking_o, 1'b1);
        repeat (20) begin
            @(posedge sys_clk_i) #1 if (!out_of_service_o) break;
        end
        chk(out_of_service_o | blocked_o, 1'b0);
        // No release-guard for a minute
        @(posedge sys_clk_i) rg_en <= 1'b0;
        release_ok_i <= 1'b1;
        role_i <= ROLE_OUT;
        {attempt_fail_i, iam_i} <= 2'h3;
        @(posedge sys_clk_i) {attempt_fail_i, iam_i} <= 2'h0;
        rx_congestion_i <= 1'b1;
        #1 chk(tx_call_fail_o, 1'b1);
        @(posedge sys_clk_i) rx_congestion_i <= 1'b0;
        for (n = 0; n < 61000 && !maint_alert_o; n++)
            @(posedge sys_clk_i) #1 c += tx_clear_fwd_o;
        chk(n >= 59995 && n <= 60005 && c >= 14 && c <= 15, 1'b1);
        chk(out_of_service_o & tx_blocking_o & !tx_clear_fwd_o, 1'b1);
        stop_test();
    end
endmodule : crs_supervisor_tb_top
